// File: src/cucc_pkg.sv
/*
 * Package for the configuration memory upset checker: state encoding,
 * widths, reset values, CRC constants and the scan instruction code.
 * Assumes nothing of its surroundings beyond a single system clock.
 */
package cucc_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int CUCC_SIG_W = 32;
	localparam int CUCC_FRAME_CRC_W = 16;
	localparam int CUCC_DIV_CNT_W = 8;
	localparam logic [31:0] CUCC_SIG_RESET = 32'h0000_0000;
	localparam logic [31:0] CUCC_REF_RESET = 32'h0000_0000;
	localparam logic [31:0] CUCC_CRC32_INIT = 32'hFFFF_FFFF;
	localparam logic [15:0] CUCC_CRC16_INIT = 16'hFFFF;
	localparam logic [7:0] CUCC_DIV_CNT_RESET = 8'h00;
	localparam logic [15:0] CUCC_FRAME_PRE_RESET = 16'h0000;
	localparam logic [4:0] CUCC_SYNC_RESET = 5'h10; // Reconfig pin idles high

	// ----------------------------------------------------------------
	// Generator polynomials
	// ----------------------------------------------------------------
	localparam logic [31:0] CUCC_CRC32_POLY = 32'h04C1_1DB7;
	localparam logic [15:0] CUCC_CRC16_POLY = 16'h8005;

	// ----------------------------------------------------------------
	// Divider limits and scan instruction
	// ----------------------------------------------------------------
	localparam int CUCC_DIV_LOG2_MAX = 8;
	localparam logic [9:0] CUCC_REF_UPDATE_SCAN_INSTR = 10'h015;

	// ----------------------------------------------------------------
	// Checker states, Gray coded in order from configuration to finish
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CUCC_ST_CONFIG = 2'b00,
		CUCC_ST_LOAD = 2'b01,
		CUCC_ST_SCAN = 2'b11,
		CUCC_ST_FINISH = 2'b10
	} cucc_state_t;

endpackage

// File: src/cucc_checker.sv
/*
 * Configuration memory upset checker: per-frame CRC during configuration,
 * continuous whole-memory CRC in user mode, signature and reference
 * registers, serial reference scan path and open-drain status pins.
 * Assumes configuration memory is read asynchronously one bit per address,
 * and that the boundary-scan controller decodes the instruction itself.
 */
// Behaviour
// R1: Drive active-high open-drain error pin when memory corruption is found.
// R2: Error pin is driven only when the checker feature is enabled.
// R3: Each configuration frame carries its own 16-bit CRC.
// R4: Shift precomputed frame CRC while computing; mismatch pulls status low.
// R5: User mode keeps one 32-bit CRC over all configuration memory.
// R6: Two 32-bit registers: computed signature and precalculated reference.
// R7: Error pin follows a non-zero signature register.
// R8: Signature holds computed versus reference compare; zero when clean.
// R9: End of configuration loads stream 32-bit CRC into storage register.
// R10: Each user pass loads the reference from storage into compare circuit.
// R11: Under reference-update instruction storage forms 32-bit scan chain.
// R12: Host may overwrite storage by scan; written value becomes new reference.
// R13: Checking keeps running while the storage register is scanned.
// R14: Host selects reference-update instruction with its 10-bit code.
// R15: Error stays high through next pass; cleared only by a clean pass.
// R16: Checker steps at sys clock divided by power of two, 1 to 256.
// R17: Checking runs continuously until reconfiguration request goes low.
// R18: Signature and error update only at completion of a full pass.
`timescale 1ns/1ps

module cucc_checker
	import cucc_pkg::*;
#(
	parameter int MEM_BITS = 1024,
	parameter int DIV_LOG2 = 0,
	parameter logic [15:0] FRAME_POLY = CUCC_CRC16_POLY,
	parameter int ADDR_W = (MEM_BITS > 1) ? $clog2(MEM_BITS) : 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Device configuration option and reconfiguration pin
	input wire logic checker_enable,
	input wire logic reconfig_request_low,
	// Configuration stream: frame data, frame CRC, end of stream
	input wire logic cfg_data_valid,
	input wire logic cfg_data_bit,
	input wire logic cfg_crc_valid,
	input wire logic cfg_crc_bit,
	input wire logic cfg_frame_done,
	input wire logic cfg_stream_done,
	input wire logic [31:0] cfg_stream_crc,
	// Configuration memory read port
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_rd_data,
	// Boundary-scan data path, instruction already decoded
	input wire logic scan_tck,
	input wire logic scan_tdi,
	input wire logic scan_shift_dr,
	input wire logic ref_update_instr_active,
	output logic scan_tdo,
	// Open-drain pins, enable high while pulling low
	output logic error_pin_out,
	output logic error_pin_oe,
	output logic cfg_status_low_out,
	output logic cfg_status_low_oe,
	// Register views and state
	output logic [31:0] crc_compare_result,
	output logic [31:0] crc_reference_value,
	output logic user_mode
);

	// Refuse parameter values the divider or address counter cannot serve
	if (DIV_LOG2 < 0 || DIV_LOG2 > CUCC_DIV_LOG2_MAX) begin
		$error("DIV_LOG2 out of range");
	end
	if (MEM_BITS < 2 || ADDR_W < $clog2(MEM_BITS)) begin
		$error("MEM_BITS or ADDR_W out of range");
	end

	// ----------------------------------------------------------------
	// CRC step functions, MSB-first shift
	// ----------------------------------------------------------------
	function automatic logic [31:0] crc32_step(input logic [31:0] crc, input logic din);
		logic fb;
		fb = crc[31] ^ din;
		crc32_step = {crc[30:0], 1'b0} ^ (fb ? CUCC_CRC32_POLY : 32'h0000_0000);
	endfunction

	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic din);
		logic fb;
		fb = crc[15] ^ din;
		crc16_step = {crc[14:0], 1'b0} ^ (fb ? FRAME_POLY : 16'h0000);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers: three stages, change taken when 2 and 3 agree
	// ----------------------------------------------------------------
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] sync1_reg, sync2_reg, sync3_reg;
	logic [NSYNC-1:0] pin_raw, pin_stable_reg, pin_stable_next;

	always_comb begin
		pin_raw = {reconfig_request_low, scan_tck, scan_tdi, scan_shift_dr,
			ref_update_instr_active};
		pin_stable_next = pin_stable_reg;
		for (int i = 0; i < NSYNC; i++) begin
			if (sync2_reg[i] == sync3_reg[i])
				pin_stable_next[i] = sync3_reg[i];
		end
	end

	// Reconfig pin resets high so a released pin is not seen as a request
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_reg <= CUCC_SYNC_RESET;
			sync2_reg <= CUCC_SYNC_RESET;
			sync3_reg <= CUCC_SYNC_RESET;
			pin_stable_reg <= CUCC_SYNC_RESET;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_stable_reg <= pin_stable_next;
		end
	end

	logic reconfig_low_s, tck_s, tdi_s, shift_s, instr_s;
	assign {reconfig_low_s, tck_s, tdi_s, shift_s, instr_s} = pin_stable_reg;

	// ----------------------------------------------------------------
	// Step divider
	// ----------------------------------------------------------------
	localparam logic [7:0] DIV_LAST = 8'((1 << DIV_LOG2) - 1);
	logic [7:0] div_cnt_reg, div_cnt_next;
	logic step;

	// Checking advances one step per divided tick
	always_comb begin
		step = (div_cnt_reg == DIV_LAST); // R16
		div_cnt_next = step ? CUCC_DIV_CNT_RESET : 8'(div_cnt_reg + 8'h01);
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			div_cnt_reg <= CUCC_DIV_CNT_RESET;
		else
			div_cnt_reg <= div_cnt_next;
	end

	// ----------------------------------------------------------------
	// Configuration-stage frame check
	// ----------------------------------------------------------------
	logic [15:0] frame_calc_reg, frame_calc_next;
	logic [15:0] frame_pre_reg, frame_pre_next;
	logic status_fail_reg, status_fail_next;
	cucc_state_t state_reg, state_next;
	logic in_config;

	assign in_config = (state_reg == CUCC_ST_CONFIG);

	// Calculated and precomputed values run side by side within a frame
	always_comb begin
		frame_calc_next = frame_calc_reg;
		frame_pre_next = frame_pre_reg;
		status_fail_next = status_fail_reg;
		if (in_config) begin
			if (cfg_data_valid)
				frame_calc_next = crc16_step(frame_calc_reg, cfg_data_bit); // R3
			if (cfg_crc_valid)
				frame_pre_next = {frame_pre_reg[14:0], cfg_crc_bit}; // R4
			if (cfg_frame_done) begin
				if (frame_calc_reg != frame_pre_reg)
					status_fail_next = 1'b1; // R4
				frame_calc_next = CUCC_CRC16_INIT;
				frame_pre_next = CUCC_FRAME_PRE_RESET;
			end
		end
		if (!reconfig_low_s)
			status_fail_next = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			frame_calc_reg <= CUCC_CRC16_INIT;
			frame_pre_reg <= CUCC_FRAME_PRE_RESET;
			status_fail_reg <= 1'b0;
		end else begin
			frame_calc_reg <= frame_calc_next;
			frame_pre_reg <= frame_pre_next;
			status_fail_reg <= status_fail_next;
		end
	end

	// ----------------------------------------------------------------
	// Storage register and its scan chain
	// ----------------------------------------------------------------
	logic [31:0] storage_reg, storage_next;
	logic tck_prev_reg;
	logic tdo_reg, tdo_next;

	// Scan shifts the storage itself; the pass works on its own copy,
	// so a scan mid-pass never disturbs the running check
	always_comb begin
		storage_next = storage_reg;
		if (in_config && cfg_stream_done && !status_fail_reg)
			storage_next = cfg_stream_crc; // R9
		else if (!in_config && instr_s && shift_s && tck_s && !tck_prev_reg)
			storage_next = {tdi_s, storage_reg[31:1]}; // R11 R12 R13
		tdo_next = (!in_config && instr_s) ? storage_next[0] : 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			storage_reg <= CUCC_REF_RESET;
			tck_prev_reg <= 1'b0;
			tdo_reg <= 1'b0;
		end else begin
			storage_reg <= storage_next;
			tck_prev_reg <= tck_s;
			tdo_reg <= tdo_next;
		end
	end

	// ----------------------------------------------------------------
	// User-mode pass over configuration memory
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(MEM_BITS - 1);
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [31:0] crc_reg, crc_next;
	logic [31:0] ref_reg, ref_next;
	logic [31:0] sig_reg, sig_next;
	logic err_reg, err_next;

	// Pass loop: load reference, walk every bit, then publish the compare
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		crc_next = crc_reg;
		ref_next = ref_reg;
		sig_next = sig_reg;
		err_next = err_reg;
		case (state_reg)
			CUCC_ST_CONFIG: begin
				if (cfg_stream_done && !status_fail_reg && checker_enable)
					state_next = CUCC_ST_LOAD;
			end
			CUCC_ST_LOAD: begin
				if (step) begin
					ref_next = storage_reg; // R10
					crc_next = CUCC_CRC32_INIT;
					addr_next = '0;
					state_next = CUCC_ST_SCAN;
				end
			end
			CUCC_ST_SCAN: begin
				if (step) begin
					crc_next = crc32_step(crc_reg, mem_rd_data); // R5
					if (addr_reg == ADDR_LAST)
						state_next = CUCC_ST_FINISH;
					else
						addr_next = ADDR_W'(addr_reg + 1'b1);
				end
			end
			CUCC_ST_FINISH: begin
				if (step) begin
					sig_next = crc_reg ^ ref_reg; // R6 R8 R18
					err_next = (sig_next != 32'h0000_0000); // R7 R15
					state_next = CUCC_ST_LOAD; // R17
				end
			end
			default: state_next = CUCC_ST_CONFIG;
		endcase
		// Reconfiguration stops checking and returns to configuration
		if (!reconfig_low_s) begin
			state_next = CUCC_ST_CONFIG; // R17
			sig_next = CUCC_SIG_RESET;
			err_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= CUCC_ST_CONFIG;
			addr_reg <= '0;
			crc_reg <= CUCC_CRC32_INIT;
			ref_reg <= CUCC_REF_RESET;
			sig_reg <= CUCC_SIG_RESET;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			crc_reg <= crc_next;
			ref_reg <= ref_next;
			sig_reg <= sig_next;
			err_reg <= err_next;
		end
	end

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	logic err_oe_reg, err_oe_next;
	logic st_oe_reg, st_oe_next;
	logic user_reg, user_next;

	// Open-drain: the pin idles high on its pull-up, so a clean pass pulls
	// it low and an error releases it
	// Pin follows the next state, so it is released on the same edge that leaves user mode
	always_comb begin
		user_next = (state_next != CUCC_ST_CONFIG);
		err_oe_next = checker_enable && user_next && !err_next; // R1 R2 R7
		st_oe_next = status_fail_next; // R4
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			err_oe_reg <= 1'b0;
			st_oe_reg <= 1'b0;
			user_reg <= 1'b0;
		end else begin
			err_oe_reg <= err_oe_next;
			st_oe_reg <= st_oe_next;
			user_reg <= user_next;
		end
	end

	assign mem_addr = addr_reg;
	assign scan_tdo = tdo_reg;
	assign error_pin_out = 1'b0;
	assign error_pin_oe = err_oe_reg;
	assign cfg_status_low_out = 1'b0;
	assign cfg_status_low_oe = st_oe_reg;
	assign crc_compare_result = sig_reg;
	assign crc_reference_value = storage_reg;
	assign user_mode = user_reg;

endmodule

// File: verif/cucc_checker_sva.sv
/*
 * Concurrent checks for the configuration memory upset checker.
 * Assumes it is bound to cucc_checker and sees only its ports.
 */
`timescale 1ns/1ps

module cucc_checker_sva
	import cucc_pkg::*;
#(
	parameter int MEM_BITS = 1024,
	parameter int DIV_LOG2 = 0,
	parameter int ADDR_W = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Controls
	input wire logic checker_enable,
	input wire logic reconfig_request_low,
	input wire logic ref_update_instr_active,
	// Observed outputs
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic scan_tdo,
	input wire logic error_pin_out,
	input wire logic error_pin_oe,
	input wire logic cfg_status_low_oe,
	input wire logic [31:0] crc_compare_result,
	input wire logic [31:0] crc_reference_value,
	input wire logic user_mode
);
	// ----
	// Cycles since the last address of a pass
	// ----
	logic [9:0] since_end_reg;
	logic [9:0] since_end_next;

	// Saturates so an idle checker never wraps to a false pass end
	always_comb begin
		since_end_next = since_end_reg;
		if (mem_addr == ADDR_W'(MEM_BITS - 1)) begin
			since_end_next = 10'h000;
		end else if (since_end_reg != 10'h3FF) begin
			since_end_next = since_end_reg + 10'h001;
		end
	end

	// Register the counter
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			since_end_reg <= 10'h3FF;
		end else begin
			since_end_reg <= since_end_next;
		end
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_scan_step;
		$changed(crc_reference_value) && user_mode && $past(user_mode);
	endsequence
	sequence s_quiet;
		(user_mode && !ref_update_instr_active) [*5];
	endsequence

	property p_open_drain;
		error_pin_out == 1'b0;
	endproperty
	property p_off_idle;
		!checker_enable [*2] |-> !error_pin_oe;
	endproperty
	property p_cfg_idle;
		!user_mode && !$past(user_mode) |-> !error_pin_oe && !scan_tdo;
	endproperty
	property p_err_follows_sig;
		user_mode && $past(user_mode) && checker_enable && $past(checker_enable)
			|-> error_pin_oe == (crc_compare_result == 32'h0000_0000);
	endproperty
	property p_sig_at_end;
		$changed(crc_compare_result) && user_mode && $past(user_mode)
			|-> since_end_reg <= 10'(2 << DIV_LOG2);
	endproperty
	property p_pass_runs;
		user_mode |-> ##[0:300] (mem_addr == ADDR_W'(MEM_BITS - 1) || !user_mode);
	endproperty
	property p_ref_shift;
		s_scan_step |-> crc_reference_value[30:0] == 31'($past(crc_reference_value) >> 1)
			&& scan_tdo == crc_reference_value[0];
	endproperty
	property p_ref_hold;
		s_quiet |=> $stable(crc_reference_value);
	endproperty
	property p_status_hold;
		reconfig_request_low [*4] ##0 cfg_status_low_oe |=> cfg_status_low_oe;
	endproperty

	a_open_drain: assert property (p_open_drain)
		else $error("error pin data not low");
	a_off_idle: assert property (p_off_idle)
		else $error("error pin driven while disabled");
	a_cfg_idle: assert property (p_cfg_idle)
		else $error("error pin or scan out active in configuration");
	a_err_follows_sig: assert property (p_err_follows_sig)
		else $error("error pin disagrees with signature");
	a_sig_at_end: assert property (p_sig_at_end)
		else $error("signature changed mid pass");
	a_pass_runs: assert property (p_pass_runs)
		else $error("memory pass stalled");
	a_ref_shift: assert property (p_ref_shift)
		else $error("reference did not shift right by one");
	a_ref_hold: assert property (p_ref_hold)
		else $error("reference changed without scan");
	a_status_hold: assert property (p_status_hold)
		else $error("status failure released early");
endmodule

bind cucc_checker cucc_checker_sva #(.MEM_BITS(MEM_BITS), .DIV_LOG2(DIV_LOG2), .ADDR_W(ADDR_W))
	u_sva (.sys_clk(sys_clk), .rst(rst), .checker_enable(checker_enable),
	.reconfig_request_low(reconfig_request_low),
	.ref_update_instr_active(ref_update_instr_active), .mem_addr(mem_addr),
	.scan_tdo(scan_tdo), .error_pin_out(error_pin_out), .error_pin_oe(error_pin_oe),
	.cfg_status_low_oe(cfg_status_low_oe), .crc_compare_result(crc_compare_result),
	.crc_reference_value(crc_reference_value), .user_mode(user_mode));

// File: verif/cucc_mem_model.sv
/*
 * Far side: configuration memory bits and the pulled-up error pin.
 * Assumes the bench owns the memory contents and may upset them.
 */
`timescale 1ns/1ps

module cucc_mem_model
	import cucc_pkg::*;
#(
	parameter int MEM_BITS = 32,
	parameter int ADDR_W = 5
) (
	// Memory side
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [MEM_BITS-1:0] contents,
	output logic mem_rd_data,
	// Monitor side
	input wire logic error_pin_out,
	input wire logic error_pin_oe,
	output logic error_level
);
	// Asynchronous bit read, so an upset shows on the next visit
	assign mem_rd_data = contents[mem_addr];
	// Pull-up wins unless the device pulls the pin low
	assign error_level = error_pin_oe ? error_pin_out : 1'b1;
endmodule

// File: verif/cucc_checker_tb.sv
/*
 * Self-checking bench: frames, stream load, upsets and reference scans.
 * Assumes one 100 MHz clock and a small memory for short passes.
 */
`timescale 1ns/1ps

module cucc_checker_tb;
	import cucc_pkg::*;
	localparam int MB = 32;
	logic sys_clk, rst, checker_enable, reconfig_request_low, mem_rd_data, user_mode;
	logic cfg_data_valid, cfg_data_bit, cfg_crc_valid, cfg_crc_bit, cfg_frame_done;
	logic cfg_stream_done, scan_tck, scan_tdi, scan_shift_dr, ref_update_instr_active;
	logic scan_tdo, error_pin_out, error_pin_oe, cfg_status_low_out, cfg_status_low_oe;
	logic error_level;
	logic [4:0] mem_addr;
	logic [31:0] cfg_stream_crc, crc_compare_result, crc_reference_value, sig_exp, v;
	logic [MB-1:0] mem;
	logic [9:0] instr;
	int errors, checked, seed, k;

	cucc_checker #(.MEM_BITS(MB), .DIV_LOG2(0)) dut (.sys_clk(sys_clk), .rst(rst),
		.checker_enable(checker_enable), .reconfig_request_low(reconfig_request_low),
		.cfg_data_valid(cfg_data_valid), .cfg_data_bit(cfg_data_bit),
		.cfg_crc_valid(cfg_crc_valid), .cfg_crc_bit(cfg_crc_bit),
		.cfg_frame_done(cfg_frame_done), .cfg_stream_done(cfg_stream_done),
		.cfg_stream_crc(cfg_stream_crc), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
		.scan_tck(scan_tck), .scan_tdi(scan_tdi), .scan_shift_dr(scan_shift_dr),
		.ref_update_instr_active(ref_update_instr_active), .scan_tdo(scan_tdo),
		.error_pin_out(error_pin_out), .error_pin_oe(error_pin_oe),
		.cfg_status_low_out(cfg_status_low_out), .cfg_status_low_oe(cfg_status_low_oe),
		.crc_compare_result(crc_compare_result), .crc_reference_value(crc_reference_value),
		.user_mode(user_mode));
	cucc_mem_model #(.MEM_BITS(MB), .ADDR_W(5)) u_mem (.mem_addr(mem_addr), .contents(mem),
		.mem_rd_data(mem_rd_data), .error_pin_out(error_pin_out),
		.error_pin_oe(error_pin_oe), .error_level(error_level));

	// Free-running system clock
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end

	// MSB-first CRC over d[0] first, 16 or 32 bits wide
	function automatic logic [31:0] crc(input logic [31:0] poly, input int w,
		input logic [MB-1:0] d);
		logic [31:0] c;
		c = (w == 32) ? CUCC_CRC32_INIT : 32'(CUCC_CRC16_INIT);
		for (int i = 0; i < MB; i++) begin
			c = ((c << 1) ^ ((c[w-1] ^ d[i]) ? poly : 32'h0)) & ((w == 32) ? 32'hFFFF_FFFF
				: 32'h0000_FFFF);
		end
		return c;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Data bits, then the frame CRC MSB first, then the compare pulse
	task automatic send_frame(input logic [MB-1:0] d, input logic [15:0] c);
		for (int i = 0; i < MB + 16; i++) begin
			@(negedge sys_clk);
			cfg_data_valid = i < MB;
			cfg_data_bit = (i < MB) ? d[i] : 1'b0;
			cfg_crc_valid = i >= MB;
			cfg_crc_bit = (i >= MB) ? c[MB + 15 - i] : 1'b0;
		end
		@(negedge sys_clk);
		{cfg_data_valid, cfg_crc_valid, cfg_frame_done} = 3'b001;
		@(negedge sys_clk);
		cfg_frame_done = 0;
		repeat (3) @(negedge sys_clk);
	endtask

	// Slow scan clock so the synchronisers see every level
	task automatic scan_ref(input logic [31:0] val);
		ref_update_instr_active = (instr == CUCC_REF_UPDATE_SCAN_INSTR);
		scan_shift_dr = 1;
		for (int i = 0; i < 32; i++) begin
			scan_tdi = val[i];
			repeat (5) @(negedge sys_clk);
			scan_tck = 1;
			repeat (5) @(negedge sys_clk);
			scan_tck = 0;
		end
		{scan_shift_dr, ref_update_instr_active} = 2'b00;
		repeat (2) @(negedge sys_clk);
	endtask

	// Two whole passes guarantee a result from settled contents
	task automatic check_pass(input logic [31:0] r);
		repeat (2 * (MB + 2) + 4) @(negedge sys_clk);
		sig_exp = crc(CUCC_CRC32_POLY, 32, mem) ^ r;
		chk("signature", sig_exp, crc_compare_result);
		chk("error pin", {31'h0, sig_exp != 32'h0}, {31'h0, error_level});
	endtask

	// Main sequence
	initial begin
		seed = 32'hb37a;
		{errors, checked} = 0;
		{rst, checker_enable, reconfig_request_low} = 3'b111;
		{cfg_data_valid, cfg_data_bit, cfg_crc_valid, cfg_crc_bit} = 4'h0;
		{cfg_frame_done, cfg_stream_done, scan_tck, scan_tdi} = 4'h0;
		{scan_shift_dr, ref_update_instr_active} = 2'b00;
		instr = CUCC_REF_UPDATE_SCAN_INSTR;
		mem = $random(seed);
		cfg_stream_crc = crc(CUCC_CRC32_POLY, 32, mem);
		repeat (10) @(negedge sys_clk);
		rst = 0;
		repeat (4) @(negedge sys_clk);
		chk("signature reset", 32'h0, crc_compare_result);
		chk("reference reset", CUCC_REF_RESET, crc_reference_value);
		send_frame(mem, 16'(crc(32'(CUCC_CRC16_POLY), 16, mem)) ^ 16'h8000);
		chk("status low", 32'h1, {31'h0, cfg_status_low_oe});
		chk("status pin data", 32'h0, {31'h0, cfg_status_low_out});
		cfg_stream_done = 1;
		@(negedge sys_clk);
		cfg_stream_done = 0;
		chk("user mode refused", 32'h0, {31'h0, user_mode});
		reconfig_request_low = 0;
		repeat (6) @(negedge sys_clk);
		reconfig_request_low = 1;
		repeat (6) @(negedge sys_clk);
		chk("status cleared", 32'h0, {31'h0, cfg_status_low_oe});
		send_frame(mem, 16'(crc(32'(CUCC_CRC16_POLY), 16, mem)));
		chk("status good frame", 32'h0, {31'h0, cfg_status_low_oe});
		cfg_stream_done = 1;
		@(negedge sys_clk);
		cfg_stream_done = 0;
		chk("stream reference", cfg_stream_crc, crc_reference_value);
		check_pass(cfg_stream_crc);
		for (int j = 0; j < 3; j++) begin
			k = (j == 0) ? 0 : (j == 1) ? MB - 1 : $unsigned($random(seed)) % MB;
			mem[k] = ~mem[k];
			check_pass(cfg_stream_crc);
			mem[k] = ~mem[k];
			check_pass(cfg_stream_crc);
		end
		v = $random(seed);
		scan_ref(v);
		chk("scanned reference", v, crc_reference_value);
		chk("scan out", {31'h0, v[0]}, {31'h0, scan_tdo});
		check_pass(v);
		scan_ref(cfg_stream_crc);
		check_pass(cfg_stream_crc);
		checker_enable = 0;
		repeat (4) @(negedge sys_clk);
		chk("pin released", 32'h0, {31'h0, error_pin_oe});
		reconfig_request_low = 0;
		repeat (6) @(negedge sys_clk);
		chk("checking stopped", 32'h0, {31'h0, user_mode});
		reconfig_request_low = 1;
		repeat (6) @(negedge sys_clk);
		cfg_stream_crc = v;
		cfg_stream_done = 1;
		@(negedge sys_clk);
		cfg_stream_done = 0;
		repeat (2) @(negedge sys_clk);
		chk("reference without checker", v, crc_reference_value);
		chk("idle without checker", 32'h0, {31'h0, user_mode});
		chk("error pin undriven", 32'h1, {31'h0, error_level});
		give_verdict;
	end

	// Run needs about 1450 cycles; allow nearly fourteen times that
	initial begin
		#200000;
		errors++;
		give_verdict;
	end
endmodule
